/* power_manager_pkg.sv */
// shared constants, types and carriers of the power manager block
package power_manager_pkg;

  // ==========================================
  // sizes
  localparam int NUM_BUS    = 3;
  localparam int DIV_W      = 3;
  localparam int PRESCALE_W = 8;
  localparam int MASK_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int HOLD_W     = 5;

  // ==========================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_CPU_SEL     = 8'h04;
  localparam logic [7:0] OFS_BUS_SEL0    = 8'h08;
  localparam logic [7:0] OFS_AHB_MASK    = 8'h14;
  localparam logic [7:0] OFS_BUS_MASK0   = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN_CLR  = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN_SET  = 8'h28;
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h2c;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h30;
  localparam logic [7:0] OFS_STRIDE      = 8'h04;

  // ==========================================
  // field positions
  localparam int CTRL_FDE_BIT  = 2;
  localparam int CTRL_BKUP_BIT = 4;
  localparam int IRQ_RDY_BIT   = 0;
  localparam int IRQ_CFD_BIT   = 1;
  localparam int CAUSE_POR     = 0;
  localparam int CAUSE_CBOD    = 1;
  localparam int CAUSE_IBOD    = 2;
  localparam int CAUSE_EXT     = 4;
  localparam int CAUSE_WDT     = 5;
  localparam int CAUSE_SW      = 6;
  localparam int PM_BUS_IDX    = 0;
  localparam int PM_BUS_BIT    = 1;
  localparam int BRIDGE_BIT    = 0;

  // ==========================================
  // values after reset
  localparam logic [DIV_W-1:0]  DIV_RST      = 3'h0;
  localparam logic [MASK_W-1:0] AHB_MASK_RST = 32'h0000007f;
  localparam logic [NUM_BUS-1:0][MASK_W-1:0] BUS_MASK_RST =
    {32'h00000302, 32'h0000001f, 32'h0000007f};
  localparam logic [1:0]        IRQ_RST      = 2'h0;
  localparam logic [7:0]        CAUSE_RST    = 8'h01;

  // ==========================================
  // counts
  localparam logic [HOLD_W-1:0] RESET_HOLD_CYCLES = 5'h10;

  // ==========================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  typedef struct packed {
    logic por;
    logic core_bod;
    logic io_bod;
    logic ext_n;
    logic wdt;
    logic sw;
  } reset_src_s;

  typedef enum logic [1:0] {
    RST_IDLE    = 2'b00,
    RST_HOLD    = 2'b01,
    RST_RELEASE = 2'b10
  } rst_state_e;

endpackage

/* power_manager_clock_reset.sv */
// power manager: prescaler, clock gating, failure detector, reset control
`timescale 1ns/1ps
module power_manager_clock_reset
  import power_manager_pkg::*;
#(
  parameter int NB = NUM_BUS
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // register port
  input  wire reg_req_s                reg_req,
  output logic [DATA_W-1:0]            rd_data,
  // clock source edge pulses and detector pause levels
  input  wire logic                    main_edge,
  input  wire logic                    backup_edge,
  input  wire logic                    ref32k_edge,
  input  wire logic                    main_unavail,
  input  wire logic                    sleep_active,
  // reset sources
  input  wire reset_src_s              rst_src,
  // clock enables
  output logic                         cpu_clk_en,
  output logic                         ahb_clk_en,
  output logic [NB-1:0]                bus_clk_en,
  output logic [MASK_W-1:0]            ahb_periph_en,
  output logic [NB-1:0][MASK_W-1:0]    bus_periph_en,
  // interrupt and resets
  output logic                         irq,
  output logic                         sys_reset,
  output logic                         debug_reset,
  output logic                         power_reset
);

  // ==========================================
  // state
  logic [PRESCALE_W-1:0]         cnt_reg;
  logic [DIV_W-1:0]              cpu_sel_reg;
  logic [DIV_W-1:0]              cpu_div_reg;
  logic [NB-1:0][DIV_W-1:0]      bus_sel_reg;
  logic [NB-1:0][DIV_W-1:0]      bus_div_reg;
  logic                          pending_reg;
  logic [MASK_W-1:0]             ahb_mask_reg;
  logic [NB-1:0][MASK_W-1:0]     bus_mask_reg;
  logic                          fde_reg;
  logic                          bkup_reg;
  logic                          seen_reg;
  logic [1:0]                    flags_reg;
  logic [1:0]                    irq_en_reg;
  logic [7:0]                    cause_reg;
  rst_state_e                    rst_state_reg;
  logic [HOLD_W-1:0]             hold_reg;
  logic                          scope_pwr_reg;
  logic                          scope_dbg_reg;
  logic [DATA_W-1:0]             rd_next;

  // ==========================================
  // register decode
  logic                          locked;
  logic                          wr;
  logic                          rd;
  logic                          sys_clr;
  logic                          ctrl_wr;
  logic                          cpu_wr;
  logic [NB-1:0]                 bus_wr;
  logic                          ahb_mask_wr;
  logic [NB-1:0]                 bus_mask_wr;
  logic                          sel_wr;
  logic                          flag_wr;

  // mask lock
  // own bus or bridge clock gone: nothing can reopen it short of reset
  assign locked = !bus_mask_reg[PM_BUS_IDX][PM_BUS_BIT] ||
                  !ahb_mask_reg[BRIDGE_BIT];
  assign sys_clr = sys_reset;
  // gated access
  // with its own clock masked the register port is dead
  assign wr = reg_req.wr && !locked && !sys_clr;
  assign rd = reg_req.rd && !locked;
  assign ctrl_wr = wr && (reg_req.addr == OFS_CTRL);
  assign cpu_wr = wr && (reg_req.addr == OFS_CPU_SEL);
  assign ahb_mask_wr = wr && (reg_req.addr == OFS_AHB_MASK);
  assign flag_wr = wr && (reg_req.addr == OFS_IRQ_FLAGS);

  // per-bus select and mask strobes
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      bus_wr[i] = wr && (reg_req.addr ==
        8'(OFS_BUS_SEL0 + OFS_STRIDE * 8'(i)));
      bus_mask_wr[i] = wr && (reg_req.addr ==
        8'(OFS_BUS_MASK0 + OFS_STRIDE * 8'(i)));
    end
  end
  assign sel_wr = cpu_wr || (|bus_wr);

  // ==========================================
  // prescaler
  logic main_tick;
  logic apply;
  logic cpu_tick;
  logic [NB-1:0] bus_tick;

  // tap of the prescaler: low d bits all ones
  function automatic logic tap_hit(
    input logic [PRESCALE_W-1:0] cnt,
    input logic [DIV_W-1:0]      d
  );
    logic [PRESCALE_W-1:0] m;
    m = 8'((8'h01 << d) - 8'h01);
    return (cnt & m) == m;
  endfunction

  // source switch
  // ticks are whole pulses, so a switch never leaves a runt
  assign main_tick = bkup_reg ? backup_edge : main_edge;

  // free running prescaler
  // no enable bit; system resets never stop it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (main_tick) begin
      cnt_reg <= 8'(cnt_reg + 8'h01);
    end
  end

  // aligned apply
  // at the wrap every tap fires at once, so all ratios change cleanly
  assign apply = pending_reg && main_tick && (&cnt_reg) && !sel_wr;

  assign cpu_tick = main_tick && tap_hit(cnt_reg, cpu_div_reg);

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      bus_tick[i] = main_tick && tap_hit(cnt_reg, bus_div_reg[i]);
    end
  end

  // ==========================================
  // division settings
  // undivided after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_sel_reg <= DIV_RST;
      bus_sel_reg <= '0;
    end else if (sys_clr) begin
      cpu_sel_reg <= DIV_RST;
      bus_sel_reg <= '0;
    end else begin
      if (cpu_wr) begin
        cpu_sel_reg <= reg_req.wdata[DIV_W-1:0];
      end
      for (int i = 0; i < NB; i++) begin
        if (bus_wr[i]) begin
          bus_sel_reg[i] <= reg_req.wdata[DIV_W-1:0];
        end
      end
    end
  end

  // shadow to active
  // unchanged fields copy their own old value, keeping their ratio
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_div_reg <= DIV_RST;
      bus_div_reg <= '0;
      pending_reg <= 1'b0;
    end else if (sys_clr) begin
      cpu_div_reg <= DIV_RST;
      bus_div_reg <= '0;
      pending_reg <= 1'b0;
    end else begin
      if (apply) begin
        cpu_div_reg <= cpu_sel_reg;
        bus_div_reg <= bus_sel_reg;
      end
      if (sel_wr) begin
        pending_reg <= 1'b1;
      end else if (apply) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // clock masks
  // default gating
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ahb_mask_reg <= AHB_MASK_RST;
      bus_mask_reg <= BUS_MASK_RST;
    end else if (sys_clr) begin
      ahb_mask_reg <= AHB_MASK_RST;
      bus_mask_reg <= BUS_MASK_RST;
    end else begin
      if (ahb_mask_wr) begin
        ahb_mask_reg <= reg_req.wdata;
      end
      for (int i = 0; i < NB; i++) begin
        if (bus_mask_wr[i]) begin
          bus_mask_reg[i] <= reg_req.wdata;
        end
      end
    end
  end

  // gated enables
  // ahb shares the cpu tick; each mask bit gates one peripheral
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en    <= 1'b0;
      ahb_clk_en    <= 1'b0;
      bus_clk_en    <= '0;
      ahb_periph_en <= '0;
      bus_periph_en <= '0;
    end else begin
      cpu_clk_en    <= cpu_tick;
      ahb_clk_en    <= cpu_tick;
      bus_clk_en    <= bus_tick;
      ahb_periph_en <= {MASK_W{cpu_tick}} & ahb_mask_reg;
      for (int i = 0; i < NB; i++) begin
        bus_periph_en[i] <= {MASK_W{bus_tick[i]}} & bus_mask_reg[i];
      end
    end
  end

  // ==========================================
  // clock failure detector
  logic monitor;
  logic fail_evt;

  assign monitor = fde_reg && !main_unavail && !sleep_active;

  // edge window
  // seen starts set so the first window after enabling is not judged short
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen_reg <= 1'b1;
    end else if (!monitor) begin
      seen_reg <= 1'b1;
    end else if (ref32k_edge) begin
      seen_reg <= main_edge;
    end else if (main_edge) begin
      seen_reg <= 1'b1;
    end
  end
  assign fail_evt = monitor && ref32k_edge && !seen_reg && !main_edge;

  // control bits
  // clearing backup only reselects the source; a live fault trips again
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fde_reg  <= 1'b0;
      bkup_reg <= 1'b0;
    end else if (sys_clr) begin
      fde_reg  <= 1'b0;
      bkup_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        fde_reg <= reg_req.wdata[CTRL_FDE_BIT];
      end
      if (fail_evt) begin
        bkup_reg <= 1'b1;
      end else if (ctrl_wr && !reg_req.wdata[CTRL_BKUP_BIT]) begin
        bkup_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // interrupt flags
  // ready flag
  // a select write drops it; the set beats a write-one clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= IRQ_RST;
    end else if (sys_clr) begin
      flags_reg <= IRQ_RST;
    end else begin
      if (apply) begin
        flags_reg[IRQ_RDY_BIT] <= 1'b1;
      end else if (sel_wr) begin
        flags_reg[IRQ_RDY_BIT] <= 1'b0;
      end else if (flag_wr && reg_req.wdata[IRQ_RDY_BIT]) begin
        flags_reg[IRQ_RDY_BIT] <= 1'b0;
      end
      if (fail_evt) begin
        flags_reg[IRQ_CFD_BIT] <= 1'b1;
      end else if (flag_wr && reg_req.wdata[IRQ_CFD_BIT]) begin
        flags_reg[IRQ_CFD_BIT] <= 1'b0;
      end
    end
  end

  // enable set and clear registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_en_reg <= IRQ_RST;
    end else if (sys_clr) begin
      irq_en_reg <= IRQ_RST;
    end else if (wr && reg_req.addr == OFS_IRQ_EN_SET) begin
      irq_en_reg <= irq_en_reg | reg_req.wdata[1:0];
    end else if (wr && reg_req.addr == OFS_IRQ_EN_CLR) begin
      irq_en_reg <= irq_en_reg & ~reg_req.wdata[1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_reg & irq_en_reg);
    end
  end

  // ==========================================
  // reset controller
  logic req_pwr;
  logic req_ext;
  logic req_any;
  logic [7:0] cause_new;

  assign req_pwr = rst_src.por || rst_src.core_bod || rst_src.io_bod;
  assign req_ext = !rst_src.ext_n;
  assign req_any = req_pwr || req_ext || rst_src.wdt || rst_src.sw;

  // highest priority source, one hot
  always_comb begin
    cause_new = 8'h00;
    if (rst_src.por) begin
      cause_new[CAUSE_POR] = 1'b1;
    end else if (rst_src.core_bod) begin
      cause_new[CAUSE_CBOD] = 1'b1;
    end else if (rst_src.io_bod) begin
      cause_new[CAUSE_IBOD] = 1'b1;
    end else if (req_ext) begin
      cause_new[CAUSE_EXT] = 1'b1;
    end else if (rst_src.wdt) begin
      cause_new[CAUSE_WDT] = 1'b1;
    end else begin
      cause_new[CAUSE_SW] = 1'b1;
    end
  end

  // cause record
  // survives system reset so boot code can read it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_reg <= CAUSE_RST;
    end else if (rst_state_reg == RST_IDLE && req_any) begin
      cause_reg <= cause_new;
    end
  end

  // sequencer and scope
  // held a fixed time, then until every source lets go
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_state_reg <= RST_IDLE;
      hold_reg      <= '0;
      scope_pwr_reg <= 1'b0;
      scope_dbg_reg <= 1'b0;
    end else begin
      unique case (rst_state_reg)
        RST_IDLE: begin
          hold_reg <= '0;
          if (req_any) begin
            rst_state_reg <= RST_HOLD;
            scope_pwr_reg <= req_pwr;
            scope_dbg_reg <= req_pwr || req_ext;
          end
        end
        RST_HOLD: begin
          hold_reg <= 5'(hold_reg + 5'h01);
          if (hold_reg == 5'(RESET_HOLD_CYCLES - 5'h01)) begin
            rst_state_reg <= RST_RELEASE;
          end
        end
        RST_RELEASE: begin
          if (!req_any) begin
            rst_state_reg <= RST_IDLE;
          end
        end
        default: begin
          rst_state_reg <= RST_IDLE;
        end
      endcase
      if (rst_state_reg != RST_IDLE) begin
        scope_pwr_reg <= scope_pwr_reg | req_pwr;
        scope_dbg_reg <= scope_dbg_reg | req_pwr | req_ext;
      end
    end
  end

  // reset outputs, one cycle behind the sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_reset   <= 1'b1;
      debug_reset <= 1'b1;
      power_reset <= 1'b1;
    end else begin
      sys_reset   <= rst_state_reg != RST_IDLE;
      debug_reset <= rst_state_reg != RST_IDLE && scope_dbg_reg;
      power_reset <= rst_state_reg != RST_IDLE && scope_pwr_reg;
    end
  end

  // ==========================================
  // read path
  always_comb begin
    rd_next = '0;
    if (reg_req.addr == OFS_CTRL) begin
      rd_next[CTRL_FDE_BIT]  = fde_reg;
      rd_next[CTRL_BKUP_BIT] = bkup_reg;
    end else if (reg_req.addr == OFS_CPU_SEL) begin
      rd_next[DIV_W-1:0] = cpu_sel_reg;
    end else if (reg_req.addr == OFS_AHB_MASK) begin
      rd_next = ahb_mask_reg;
    end else if (reg_req.addr == OFS_IRQ_EN_SET ||
                 reg_req.addr == OFS_IRQ_EN_CLR) begin
      rd_next[1:0] = irq_en_reg;
    end else if (reg_req.addr == OFS_IRQ_FLAGS) begin
      rd_next[1:0] = flags_reg;
    end else if (reg_req.addr == OFS_RESET_CAUSE) begin
      rd_next[7:0] = cause_reg;
    end
    for (int i = 0; i < NB; i++) begin
      if (reg_req.addr == 8'(OFS_BUS_SEL0 + OFS_STRIDE * 8'(i))) begin
        rd_next[DIV_W-1:0] = bus_sel_reg[i];
      end
      if (reg_req.addr == 8'(OFS_BUS_MASK0 + OFS_STRIDE * 8'(i))) begin
        rd_next = bus_mask_reg[i];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd ? rd_next : '0;
    end
  end

endmodule

/* power_manager_checker.sv */
// assertion checker watching the power manager ports
`timescale 1ns/1ps
module power_manager_checker
  import power_manager_pkg::*;
#(
  parameter int NB = NUM_BUS
) (
  // clock and reset
  input wire logic                      ref_clk,
  input wire logic                      rst,
  // sources
  input wire logic                      main_edge,
  input wire logic                      backup_edge,
  input wire reset_src_s                rst_src,
  // clock enables
  input wire logic                      cpu_clk_en,
  input wire logic                      ahb_clk_en,
  input wire logic [NB-1:0]             bus_clk_en,
  input wire logic [MASK_W-1:0]         ahb_periph_en,
  input wire logic [NB-1:0][MASK_W-1:0] bus_periph_en,
  // resets
  input wire logic                      sys_reset,
  input wire logic                      debug_reset,
  input wire logic                      power_reset
);
  // ==========================================
  // one domain, so clocking and disable are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // a reset hold lasts at least sixteen cycles
  sequence held_16;
    sys_reset [*8] ##1 sys_reset [*8];
  endsequence
  sequence dbg_up;
    sys_reset && debug_reset;
  endsequence

  ahb_follows_a: assert property (ahb_clk_en == cpu_clk_en)
    else $error("ahb tick differs from cpu tick");
  tick_source_a: assert property ((cpu_clk_en || |bus_clk_en) |-> $past(main_edge || backup_edge))
    else $error("tick without a main clock edge");
  ahb_gate_a: assert property ((ahb_periph_en & ~{MASK_W{ahb_clk_en}}) == '0)
    else $error("peripheral tick without ahb tick");
  bus_gate_a: assert property ((bus_periph_en[NB-1] & ~{MASK_W{bus_clk_en[NB-1]}}) == '0)
    else $error("peripheral tick without bus tick");
  power_scope_a: assert property (power_reset |-> dbg_up)
    else $error("power reset without wider scope");
  debug_scope_a: assert property (debug_reset |-> sys_reset)
    else $error("debug reset without system reset");
  hold_len_a: assert property ($rose(sys_reset) |-> held_16)
    else $error("reset hold too short");
  ext_pin_a: assert property (!rst_src.ext_n |-> ##[1:3] dbg_up)
    else $error("pin low without reset");
  power_src_a: assert property ((rst_src.por || rst_src.core_bod || rst_src.io_bod) |-> ##[1:3] power_reset)
    else $error("power source without power reset");
endmodule

bind power_manager_clock_reset power_manager_checker #(.NB(NB)) power_manager_checker_i (
  .ref_clk(ref_clk), .rst(rst), .main_edge(main_edge), .backup_edge(backup_edge),
  .rst_src(rst_src), .cpu_clk_en(cpu_clk_en), .ahb_clk_en(ahb_clk_en),
  .bus_clk_en(bus_clk_en), .ahb_periph_en(ahb_periph_en), .bus_periph_en(bus_periph_en),
  .sys_reset(sys_reset), .debug_reset(debug_reset), .power_reset(power_reset));

/* clock_source_model.sv */
// model of the clock sources: main, backup and slow reference edges
`timescale 1ns/1ps
module clock_source_model #(
  parameter int BACKUP_DIV = 6,
  parameter int REF_DIV    = 40
) (
  // clock
  input  wire logic ref_clk,
  // control
  input  wire logic main_stop,
  // edge pulses
  output logic      main_edge,
  output logic      backup_edge,
  output logic      ref32k_edge
);
  logic ph     = 1'b0;
  int   bk_cnt = 0;
  int   rf_cnt = 0;

  // ==========================================
  // main far faster
  // main edge every other cycle, twenty per reference period
  always_ff @(posedge ref_clk) begin
    ph <= !ph;
  end
  assign main_edge = ph && !main_stop;

  // backup and reference run free, they never fail here
  always_ff @(posedge ref_clk) begin
    bk_cnt <= (bk_cnt == BACKUP_DIV - 1) ? 0 : bk_cnt + 1;
    rf_cnt <= (rf_cnt == REF_DIV - 1) ? 0 : rf_cnt + 1;
  end
  assign backup_edge = (bk_cnt == 0);
  assign ref32k_edge = (rf_cnt == 0);
endmodule

/* power_manager_clock_reset_bench.sv */
// self-checking bench for the power manager block
`timescale 1ns/1ps
module power_manager_clock_reset_bench;
  import power_manager_pkg::*;
  // ==========================================
  // signals
  logic                           ref_clk;
  logic                           rst;
  reg_req_s                       reg_req;
  logic [DATA_W-1:0]              rd_data;
  logic                           main_edge, backup_edge, ref32k_edge;
  logic                           main_unavail, sleep_active, main_stop;
  reset_src_s                     rst_src;
  logic                           cpu_clk_en, ahb_clk_en, irq;
  logic [NUM_BUS-1:0]             bus_clk_en;
  logic [MASK_W-1:0]              ahb_periph_en;
  logic [NUM_BUS-1:0][MASK_W-1:0] bus_periph_en;
  logic                           sys_reset, debug_reset, power_reset;
  int                             n_fail, samples_checked;
  int                             tk [8];

  power_manager_clock_reset power_manager_clock_reset_i (
    .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .rd_data(rd_data),
    .main_edge(main_edge), .backup_edge(backup_edge), .ref32k_edge(ref32k_edge),
    .main_unavail(main_unavail), .sleep_active(sleep_active), .rst_src(rst_src),
    .cpu_clk_en(cpu_clk_en), .ahb_clk_en(ahb_clk_en), .bus_clk_en(bus_clk_en),
    .ahb_periph_en(ahb_periph_en), .bus_periph_en(bus_periph_en), .irq(irq),
    .sys_reset(sys_reset), .debug_reset(debug_reset), .power_reset(power_reset));

  clock_source_model clock_source_model_i (
    .ref_clk(ref_clk), .main_stop(main_stop), .main_edge(main_edge),
    .backup_edge(backup_edge), .ref32k_edge(ref32k_edge));

  // ==========================================
  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // register port: one strobe cycle, read data in the cycle after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req <= '0;
    #1 chk(rd_data, exp);
  endtask

  // bounded wait on irq (0) or system reset (1)
  task automatic wait_for(input bit which, input logic lvl, input int max);
    int k;
    k = 0;
    while (((which ? sys_reset : irq) !== lvl) && k < max) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk(which ? sys_reset : irq, lvl);
  endtask

  // tick counts over n cycles
  task automatic count(input int n);
    tk = '{default: 0};
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      tk[0] += cpu_clk_en;
      tk[1] += ahb_clk_en;
      for (int b = 0; b < 3; b++) tk[2+b] += bus_clk_en[b];
      tk[5] += ahb_periph_en[0];
      tk[6] += bus_periph_en[2][0];
      tk[7] += bus_periph_en[2][2];
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================
  // hang guard, far above the expected run
  initial begin
    #(20 * 30000);
    n_fail++;
    wrap_up();
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    rst = 1'b1;
    reg_req = '0;
    main_stop = 1'b0;
    main_unavail = 1'b0;
    sleep_active = 1'b0;
    rst_src = 6'h04;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(OFS_RESET_CAUSE, 32'h1);
    rdchk(OFS_CPU_SEL, 32'h0);
    rdchk(OFS_AHB_MASK, AHB_MASK_RST);
    for (int i = 0; i < 3; i++) rdchk(8'(OFS_BUS_MASK0 + 4 * i), BUS_MASK_RST[i]);
    rdchk(8'hfc, 32'h0);
    count(512);
    for (int i = 0; i < 6; i++) chk(tk[i], 256);
    chk(tk[6] + tk[7], 0);
    wr(OFS_BUS_MASK0 + 8'h08, 32'h303);
    rdchk(OFS_BUS_MASK0 + 8'h08, 32'h303);
    count(512);
    chk(tk[6], 256);
    chk(tk[7], 0);
    // new ratios, cpu never slower than any bus
    wr(OFS_IRQ_EN_SET, 32'h3);
    wr(OFS_CPU_SEL, 32'h2);
    wr(OFS_BUS_SEL0, 32'h2);
    wr(OFS_BUS_SEL0 + 8'h04, 32'h3);
    wr(OFS_BUS_SEL0 + 8'h08, 32'h7);
    wait_for(0, 1'b1, 700);
    rdchk(OFS_IRQ_FLAGS, 32'h1);
    wr(OFS_IRQ_FLAGS, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq, 1'b0);
    count(512);
    chk(tk[0], 64);
    chk(tk[1], 64);
    chk(tk[2], 64);
    chk(tk[3], 32);
    chk(tk[4], 2);
    // change one bus only, the rest keep their ratio
    wait_for(0, 1'b0, 4);
    wr(OFS_BUS_SEL0 + 8'h04, 32'h4);
    rdchk(OFS_IRQ_FLAGS, 32'h0);
    wait_for(0, 1'b1, 700);
    wr(OFS_IRQ_FLAGS, 32'h1);
    count(512);
    chk(tk[0], 64);
    chk(tk[3], 16);
    // detector paused, then a real failure
    @(posedge ref_clk);
    main_unavail <= 1'b1;
    main_stop <= 1'b1;
    wr(OFS_CTRL, 32'h4);
    repeat (150) @(posedge ref_clk);
    main_unavail <= 1'b0;
    sleep_active <= 1'b1;
    repeat (150) @(posedge ref_clk);
    rdchk(OFS_IRQ_FLAGS, 32'h0);
    @(posedge ref_clk);
    sleep_active <= 1'b0;
    wait_for(0, 1'b1, 300);
    rdchk(OFS_CTRL, 32'h14);
    rdchk(OFS_IRQ_FLAGS, 32'h2);
    count(120);
    chk(tk[0], 5);
    chk(tk[2], 5);
    wr(OFS_CTRL, 32'h0);
    rdchk(OFS_CTRL, 32'h0);
    wr(OFS_IRQ_FLAGS, 32'h2);
    wr(OFS_CTRL, 32'h4);
    wait_for(0, 1'b1, 300);
    main_stop <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    // own bus clock masked: the block locks itself
    wr(OFS_BUS_MASK0, 32'h7d);
    rdchk(OFS_RESET_CAUSE, 32'h0);
    wr(OFS_AHB_MASK, 32'h0);
    count(96);
    chk(tk[5], 12);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      rst_src <= 6'h04 ^ (6'h20 >> i);
      repeat (4) @(posedge ref_clk);
      #1 chk({power_reset, debug_reset, sys_reset}, (i < 3) ? 7 : (i == 3) ? 3 : 1);
      @(posedge ref_clk);
      rst_src <= 6'h04;
      // prescaler and enables keep running through a system reset
      count(16);
      chk(tk[0], 8);
      wait_for(1, 1'b0, 100);
      rdchk(OFS_RESET_CAUSE, 32'h1 << ((i < 3) ? i : i + 1));
    end
    rdchk(OFS_BUS_MASK0, 32'h7f);
    rdchk(OFS_CPU_SEL, 32'h0);
    wr(OFS_AHB_MASK, 32'h1);
    rdchk(OFS_AHB_MASK, 32'h1);
    wrap_up();
  end
endmodule
